// ===== hdl/acsm_mapper.sv
// Slot and output-line mapper for channels 2 to 4 of the audio serial port
//
// What this block does
// R01: Line-select bit zero drives primary output, one drives general pin one.
// R02: Slot codes 0-31 mean TDM slot code, or left-half slot code.
// R03: Slot codes 32-63 mean TDM slot code, or right-half slot code minus 32.
// R04: Channel 2 resets to slot code one on the primary line.
// R05: Channel 3 register at index 0x0d resets to slot two, primary line.
// R06: Channel 4 register at index 0x0e resets to slot three, primary line.
// R07: Drive only in the assigned slot and line; bit 7 reads zero.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module acsm_mapper
    import acsm_pkg::*;
#(
    parameter int ADDR_W    = 8,                      // AXI address width
    parameter int SLOT_BITS = 32                      // Bit clocks per slot
) (
    input  wire logic                 mclk,               // Register clock, 50 MHz
    input  wire logic                 rst,                // Async reset, high
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,       // Write address
    input  wire logic                 s_axi_awvalid,      // Write address valid
    output logic                      s_axi_awready,      // Write address ready
    input  wire logic [31:0]          s_axi_wdata,        // Write data
    input  wire logic [3:0]           s_axi_wstrb,        // Write byte enables
    input  wire logic                 s_axi_wvalid,       // Write data valid
    output logic                      s_axi_wready,       // Write data ready
    output logic [1:0]                s_axi_bresp,        // Write response
    output logic                      s_axi_bvalid,       // Write response valid
    input  wire logic                 s_axi_bready,       // Write response ready
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,       // Read address
    input  wire logic                 s_axi_arvalid,      // Read address valid
    output logic                      s_axi_arready,      // Read address ready
    output logic [31:0]               s_axi_rdata,        // Read data
    output logic [1:0]                s_axi_rresp,        // Read response
    output logic                      s_axi_rvalid,       // Read data valid
    input  wire logic                 s_axi_rready,       // Read data ready
    input  wire logic                 link_clk,           // Serial bit clock
    input  wire logic                 frame_start,        // Bit 0 of slot 0, link clock
    input  wire logic                 half_sel,           // High in right half, link clock
    input  wire logic [SLOT_BITS-1:0] chan_two_sample,    // Channel 2 word, link clock
    input  wire logic [SLOT_BITS-1:0] chan_three_sample,  // Channel 3 word, link clock
    input  wire logic [SLOT_BITS-1:0] chan_four_sample,   // Channel 4 word, link clock
    output logic                      primary_serial_out, // Primary data line
    output logic                      primary_serial_oe,  // Primary line driven
    output logic                      general_pin_one,    // Secondary data line
    output logic                      general_pin_one_oe  // Secondary line driven
);
    localparam int BW    = (SLOT_BITS > 1) ? $clog2(SLOT_BITS) : 1;
    localparam int SNAPW = ACSM_NUM_CH * ACSM_MAP_W + 1;

    // Elaboration checks
    if (ADDR_W < 8) begin : g_chk_addr
        $error("ADDR_W must be at least 8");
    end
    if (SLOT_BITS < 2 || SLOT_BITS > 64) begin : g_chk_slot
        $error("SLOT_BITS must lie in 2..64");
    end

    // ---------------- Register side ----------------
    logic                  aw_held_q, w_held_q, bvalid_q, rvalid_q;
    logic [ADDR_W-1:0]     waddr_q;
    logic [7:0]            wdata_q;
    logic                  wstrb0_q;
    logic [1:0]            bresp_q, rresp_q;
    logic [31:0]           rdata_q;
    logic [ACSM_MAP_W-1:0] map_q [ACSM_NUM_CH];
    logic                  fmt_q;
    logic                  dirty_q, req_tgl_q, ack_s1_q, ack_s2_q;
    logic [SNAPW-1:0]      snap_q;
    logic                  act_s1_q, act_s2_q, ack_l_q, active_q;

    // Handshake readiness; one write and one read in flight
    wire aw_fire = s_axi_awvalid & s_axi_awready;
    wire w_fire  = s_axi_wvalid & s_axi_wready;
    wire ar_fire = s_axi_arvalid & s_axi_arready;
    wire wr_do   = aw_held_q & w_held_q & ~bvalid_q;
    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready  = ~w_held_q & ~bvalid_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // Write decode
    wire ws_ch2  = waddr_q == ADDR_W'(ACSM_CH2_ADDR);
    wire ws_ch3  = waddr_q == ADDR_W'(ACSM_CH3_ADDR); // R05
    wire ws_ch4  = waddr_q == ADDR_W'(ACSM_CH4_ADDR); // R06
    wire ws_cfg  = waddr_q == ADDR_W'(ACSM_CFG_ADDR);
    wire ws_stat = waddr_q == ADDR_W'(ACSM_STAT_ADDR);
    wire ws_ok   = ws_ch2 | ws_ch3 | ws_ch4 | ws_cfg | ws_stat;
    wire wr_en   = wr_do & wstrb0_q;
    wire [ACSM_NUM_CH-1:0] ws_map = {ws_ch4, ws_ch3, ws_ch2};

    // Read decode; only bits 6:0 are stored, so bit 7 and up read zero
    wire rs_ch2  = s_axi_araddr == ADDR_W'(ACSM_CH2_ADDR);
    wire rs_ch3  = s_axi_araddr == ADDR_W'(ACSM_CH3_ADDR);
    wire rs_ch4  = s_axi_araddr == ADDR_W'(ACSM_CH4_ADDR);
    wire rs_cfg  = s_axi_araddr == ADDR_W'(ACSM_CFG_ADDR);
    wire rs_stat = s_axi_araddr == ADDR_W'(ACSM_STAT_ADDR);
    wire rs_ok   = rs_ch2 | rs_ch3 | rs_ch4 | rs_cfg | rs_stat;
    wire busy    = req_tgl_q ^ ack_s2_q;
    wire [1:0]  stat_word = {act_s2_q, dirty_q | busy};
    wire [31:0] rd_mux =
        rs_ch2  ? {25'h0, map_q[0]} :                 // R07
        rs_ch3  ? {25'h0, map_q[1]} :
        rs_ch4  ? {25'h0, map_q[2]} :
        rs_cfg  ? {31'h0, fmt_q}    :
        rs_stat ? {30'h0, stat_word} : 32'h0;

    // Address and data captured independently, in either order
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            waddr_q   <= '0;
            wdata_q   <= 8'h00;
            wstrb0_q  <= 1'b0;
        end else begin
            if (aw_fire) begin
                aw_held_q <= 1'b1;
                waddr_q   <= s_axi_awaddr;
            end else if (wr_do) begin
                aw_held_q <= 1'b0;
            end
            if (w_fire) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata[7:0];
                wstrb0_q <= s_axi_wstrb[0];
            end else if (wr_do) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Responses; unmapped addresses answer with an error
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= ACSM_RESP_OK;
            rvalid_q <= 1'b0;
            rresp_q  <= ACSM_RESP_OK;
            rdata_q  <= 32'h0;
        end else begin
            if (wr_do) begin
                bvalid_q <= 1'b1;
                bresp_q  <= ws_ok ? ACSM_RESP_OK : ACSM_RESP_ERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (ar_fire) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_mux;
                rresp_q  <= rs_ok ? ACSM_RESP_OK : ACSM_RESP_ERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Mapping and framing registers; the status word ignores writes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            map_q[0] <= ACSM_CH2_RST;                 // R04
            map_q[1] <= ACSM_CH3_RST;                 // R05
            map_q[2] <= ACSM_CH4_RST;                 // R06
            fmt_q    <= ACSM_FMT_RST;
        end else begin
            for (int i = 0; i < ACSM_NUM_CH; i++) begin
                if (wr_en && ws_map[i]) begin
                    map_q[i] <= wdata_q[ACSM_MAP_W-1:0]; // R07
                end
            end
            if (wr_en && ws_cfg) begin
                fmt_q <= wdata_q[ACSM_FMT_BIT];
            end
        end
    end

    // Toggle handshake; snapshot is frozen until the link side echoes it
    wire launch = dirty_q & ~busy;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dirty_q   <= 1'b0;
            req_tgl_q <= 1'b0;
            snap_q    <= {ACSM_FMT_RST, ACSM_CH4_RST, ACSM_CH3_RST, ACSM_CH2_RST};
            ack_s1_q  <= 1'b0;
            ack_s2_q  <= 1'b0;
            act_s1_q  <= 1'b0;
            act_s2_q  <= 1'b0;
        end else begin
            dirty_q  <= (wr_en & (ws_cfg | (|ws_map))) | (dirty_q & ~launch);
            ack_s1_q <= ack_l_q;
            ack_s2_q <= ack_s1_q;
            act_s1_q <= active_q;
            act_s2_q <= act_s1_q;
            if (launch) begin
                req_tgl_q <= ~req_tgl_q;
                snap_q    <= {fmt_q, map_q[2], map_q[1], map_q[0]};
            end
        end
    end

    // ---------------- Link side ----------------
    logic [1:0]            lrst_q;
    logic                  req_s1_q, req_s2_q;
    logic [SNAPW-1:0]      shadow_q;
    logic                  half_q;
    logic [BW-1:0]         bit_q;
    logic [ACSM_SLOT_W-1:0] slot_q;
    logic                  pri_q, pri_oe_q, sec_q, sec_oe_q;

    // Reset for the link domain: asserts at once, releases on link_clk
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            lrst_q <= 2'b11;
        end else begin
            lrst_q <= {lrst_q[0], 1'b0};
        end
    end
    wire link_rst = lrst_q[1];

    // Request toggle sync; mapping changes take effect between bits
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            ack_l_q  <= 1'b0;
            shadow_q <= {ACSM_FMT_RST, ACSM_CH4_RST, ACSM_CH3_RST, ACSM_CH2_RST};
        end else begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
            ack_l_q  <= req_s2_q;
            if (req_s2_q != ack_l_q) begin
                shadow_q <= snap_q;
            end
        end
    end

    // Position of this bit; a half change restarts counting in LR framing
    wire       fmt_lr  = shadow_q[SNAPW-1] == ACSM_FMT_LR;
    wire       restart = frame_start | (fmt_lr & (half_sel ^ half_q));
    wire       wrap    = bit_q == BW'(SLOT_BITS - 1);
    wire [BW-1:0] bit_inc = bit_q + BW'(1);
    wire [ACSM_SLOT_W-1:0] slot_inc = slot_q + ACSM_SLOT_W'(1);
    wire [BW-1:0] cur_bit = (restart | wrap) ? '0 : bit_inc;
    wire [ACSM_SLOT_W-1:0] cur_slot = restart ? '0 : (wrap ? slot_inc : slot_q);
    wire       live    = frame_start | active_q;
    wire [ACSM_SLOT_W-1:0] eff_slot =
        fmt_lr ? {half_sel, cur_slot[4:0]} : cur_slot; // R02 R03
    wire [BW-1:0] msb_idx = BW'(SLOT_BITS - 1) - cur_bit;

    wire [SLOT_BITS-1:0] samp [ACSM_NUM_CH];
    assign samp[0] = chan_two_sample;
    assign samp[1] = chan_three_sample;
    assign samp[2] = chan_four_sample;

    // Per-channel slot match and line choice
    logic [ACSM_NUM_CH-1:0] hit, on_sec, bitv;
    for (genvar c = 0; c < ACSM_NUM_CH; c++) begin : g_ch
        wire [ACSM_MAP_W-1:0] m = shadow_q[c*ACSM_MAP_W +: ACSM_MAP_W];
        assign hit[c]    = live & (m[ACSM_SLOT_W-1:0] == eff_slot); // R02 R03 R07
        assign on_sec[c] = m[ACSM_LINE_BIT];                       // R01
        assign bitv[c]   = samp[c][msb_idx];
    end
    wire [ACSM_NUM_CH-1:0] pri_hit = hit & ~on_sec;
    wire [ACSM_NUM_CH-1:0] sec_hit = hit & on_sec;
    // Lower channel wins if two share a slot on one line
    wire pri_d = pri_hit[0] ? bitv[0] : pri_hit[1] ? bitv[1] : bitv[2];
    wire sec_d = sec_hit[0] ? bitv[0] : sec_hit[1] ? bitv[1] : bitv[2];

    // Counters and registered pins; one bit clock of latency
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            active_q <= 1'b0;
            half_q   <= 1'b0;
            bit_q    <= '0;
            slot_q   <= '0;
            pri_q    <= 1'b0;
            pri_oe_q <= 1'b0;
            sec_q    <= 1'b0;
            sec_oe_q <= 1'b0;
        end else begin
            active_q <= live;
            half_q   <= half_sel;
            bit_q    <= cur_bit;
            slot_q   <= cur_slot;
            pri_oe_q <= |pri_hit;                     // R01 R07
            sec_oe_q <= |sec_hit;                     // R01 R07
            pri_q    <= (|pri_hit) & pri_d;
            sec_q    <= (|sec_hit) & sec_d;
        end
    end
    assign primary_serial_out = pri_q;
    assign primary_serial_oe  = pri_oe_q;
    assign general_pin_one    = sec_q;
    assign general_pin_one_oe = sec_oe_q;

    // ---------------- Checks ----------------
    wire [ACSM_SLOT_W-1:0] code2 = shadow_q[ACSM_SLOT_W-1:0];

    ch2_reset_a: assert property (@(posedge mclk) disable iff (rst) // R04
        $past(rst) |-> map_q[0] == ACSM_CH2_RST) else $error("ch2 reset value wrong");
    ch3_reset_a: assert property (@(posedge mclk) disable iff (rst) // R05
        $past(rst) |-> map_q[1] == ACSM_CH3_RST) else $error("ch3 reset value wrong");
    ch4_reset_a: assert property (@(posedge mclk) disable iff (rst) // R06
        $past(rst) |-> map_q[2] == ACSM_CH4_RST) else $error("ch4 reset value wrong");
    resv_zero_a: assert property (@(posedge mclk) disable iff (rst) // R07
        s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0) else $error("reserved bits nonzero");
    bresp_hold_a: assert property (@(posedge mclk) disable iff (rst)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    line_pri_a: assert property (@(posedge link_clk) disable iff (link_rst) // R01
        hit[0] && !on_sec[0] |=> primary_serial_oe && primary_serial_out == $past(bitv[0]))
        else $error("ch2 not on primary line");
    line_sec_a: assert property (@(posedge link_clk) disable iff (link_rst) // R01
        hit[0] && on_sec[0] |=> general_pin_one_oe && general_pin_one == $past(bitv[0]))
        else $error("ch2 not on secondary line");
    tdm_slot_a: assert property (@(posedge link_clk) disable iff (link_rst) // R02
        !fmt_lr && hit[0] |-> cur_slot == code2) else $error("tdm slot mismatch");
    left_half_a: assert property (@(posedge link_clk) disable iff (link_rst) // R02
        fmt_lr && hit[0] && !code2[5] |-> !half_sel && cur_slot[4:0] == code2[4:0])
        else $error("left half slot mismatch");
    right_half_a: assert property (@(posedge link_clk) disable iff (link_rst) // R03
        fmt_lr && hit[0] && code2[5] |-> half_sel && cur_slot[4:0] == code2[4:0])
        else $error("right half slot mismatch");
    idle_quiet_a: assert property (@(posedge link_clk) disable iff (link_rst) // R07
        hit == '0 |=> !primary_serial_oe && !general_pin_one_oe)
        else $error("line driven outside slot");

    pri_drive_c: cover property (@(posedge link_clk) disable iff (link_rst) |pri_hit);
    sec_drive_c: cover property (@(posedge link_clk) disable iff (link_rst) |sec_hit);
    reload_c: cover property (@(posedge link_clk) disable iff (link_rst)
        req_s2_q != ack_l_q);
endmodule

// ===== hdl/acsm_pkg.sv
// Constants and types shared by the audio channel slot mapper
package acsm_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] ACSM_CH2_IDX   = 8'h0c;
    localparam logic [7:0] ACSM_CH3_IDX   = 8'h0d;
    localparam logic [7:0] ACSM_CH4_IDX   = 8'h0e;
    localparam logic [7:0] ACSM_CH2_ADDR  = {ACSM_CH2_IDX[5:0], 2'b00};
    localparam logic [7:0] ACSM_CH3_ADDR  = {ACSM_CH3_IDX[5:0], 2'b00};
    localparam logic [7:0] ACSM_CH4_ADDR  = {ACSM_CH4_IDX[5:0], 2'b00};
    localparam logic [7:0] ACSM_CFG_ADDR  = 8'h40;
    localparam logic [7:0] ACSM_STAT_ADDR = 8'h44;

    // Mapping register layout: bit 7 reserved, bit 6 line, bits 5:0 slot
    localparam int         ACSM_LINE_BIT  = 6;
    localparam int         ACSM_SLOT_W    = 6;
    localparam int         ACSM_MAP_W     = 7;
    localparam int         ACSM_NUM_CH    = 3;

    // Values after reset
    localparam logic [6:0] ACSM_CH2_RST   = 7'h01;
    localparam logic [6:0] ACSM_CH3_RST   = 7'h02;
    localparam logic [6:0] ACSM_CH4_RST   = 7'h03;
    localparam logic       ACSM_FMT_RST   = 1'b0;

    // Control and status bit positions
    localparam int         ACSM_FMT_BIT   = 0;
    localparam int         ACSM_PEND_BIT  = 0;
    localparam int         ACSM_ACT_BIT   = 1;

    // AXI response codes
    localparam logic [1:0] ACSM_RESP_OK   = 2'h0;
    localparam logic [1:0] ACSM_RESP_ERR  = 2'h2;

    // Framing: TDM, or left/right halves for I2S and left-justified
    typedef enum logic {ACSM_FMT_TDM, ACSM_FMT_LR} acsm_fmt_t;
endpackage

// ===== tb/acsm_host_model.sv
// Receiving host model: framing source and per-slot capture of both data lines
`timescale 1ns/100ps
module acsm_host_model (
    input  wire logic link_clk,    // Bit clock
    input  wire logic run,         // Start framing
    input  wire logic lr,          // Two halves of 16 slots
    input  wire logic clr,         // Wipe captures
    input  wire logic prim_d,      // Primary data
    input  wire logic prim_oe,     // Primary driven
    input  wire logic gen_d,       // Secondary data
    input  wire logic gen_oe,      // Secondary driven
    output logic      frame_start, // Slot 0 bit 0
    output logic      half_sel     // Right half flag
);
    logic [8:0] pos_q     = 9'h000;
    logic [8:0] last_q    = 9'h000;
    logic       started_q = 1'b0;
    logic [5:0] ix;
    logic [2:0] bi;
    logic       drv [2][64];
    logic [7:0] cap [2][64];

    // Eight bits per slot; halves kept short so a design counting TDM slots shows up
    assign frame_start = started_q && (pos_q == 9'h000);
    assign half_sel    = lr ? pos_q[7] : pos_q[8];
    assign ix          = lr ? {last_q[7], 1'b0, last_q[6:3]} : last_q[8:3];
    assign bi          = 3'h7 - last_q[2:0];

    // Free-running position once started
    always @(posedge link_clk) begin
        started_q <= run;
        last_q    <= pos_q;
        if (!started_q || (lr ? pos_q[7:0] == 8'hff : pos_q == 9'h1ff))
            pos_q <= 9'h000;
        else
            pos_q <= pos_q + 9'h001;
    end

    // Bit of position p is on the line one edge later; cleared so stale frames cannot pass
    always @(posedge link_clk) begin
        if (clr) begin
            for (int l = 0; l < 2; l++)
                for (int s = 0; s < 64; s++) begin
                    drv[l][s] = 1'b0;
                    cap[l][s] = 8'h00;
                end
        end else if (started_q) begin
            if (prim_oe === 1'b1) begin
                drv[0][ix]     = 1'b1;
                cap[0][ix][bi] = prim_d;
            end
            if (gen_oe === 1'b1) begin
                drv[1][ix]     = 1'b1;
                cap[1][ix][bi] = gen_d;
            end
        end
    end
endmodule

// ===== tb/test_acsm_mapper.sv
// Self-checking bench for the audio channel slot mapper
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_acsm_mapper
    import acsm_pkg::*;
;
    // Asymmetric words so a reversed bit order shows
    localparam logic [7:0] S2 = 8'hd2;
    localparam logic [7:0] S3 = 8'h5c;
    localparam logic [7:0] S4 = 8'h39;
    logic        mclk, link_clk = 1'b0, rst = 1'b1, run = 1'b0, lr = 1'b0, clr = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        frame_start, half_sel, primary_serial_out, primary_serial_oe;
    logic        general_pin_one, general_pin_one_oe;
    int          failures = 0, n_tests = 0;

    // Clocks; link clock offset so the domains never line up
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        #1.3;
        forever #3 link_clk = ~link_clk;
    end

    acsm_mapper #(.SLOT_BITS(8)) acsm_mapper_i (
        .mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_clk, .frame_start, .half_sel,
        .chan_two_sample(S2), .chan_three_sample(S3), .chan_four_sample(S4),
        .primary_serial_out, .primary_serial_oe, .general_pin_one, .general_pin_one_oe
    );
    acsm_host_model acsm_host_model_i (
        .link_clk, .run, .lr, .clr, .prim_d(primary_serial_out), .prim_oe(primary_serial_oe),
        .gen_d(general_pin_one), .gen_oe(general_pin_one_oe), .frame_start, .half_sel
    );

    // Write: address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 40);
        if (n == 40) failures++;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        s_axi_awaddr <= ~a;
        s_axi_wdata  <= ~d;
        @(posedge mclk);
    endtask

    // Read: address held until taken, data taken at the rvalid edge
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 40);
        if (n == 40) failures++;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        s_axi_araddr <= ~a;
        @(posedge mclk);
    endtask

    task automatic set_map(input logic [6:0] m2, m3, m4, input logic f);
        logic [1:0] r;
        logic [7:0] ad [4];
        logic [6:0] v  [4];
        ad = '{ACSM_CH2_ADDR, ACSM_CH3_ADDR, ACSM_CH4_ADDR, ACSM_CFG_ADDR};
        v  = '{m2, m3, m4, {6'h00, f}};
        for (int i = 0; i < 4; i++) begin
            axi_wr(ad[i], {25'h0000000, v[i]}, 4'hf, r);
            `CHK(r, ACSM_RESP_OK)
        end
    endtask

    // Let the setting cross and settle, then capture more than one whole frame
    task automatic check_map(input logic [6:0] m2, m3, m4);
        logic [6:0] m   [3];
        logic [7:0] smp [3];
        logic       e_drv;
        logic [7:0] e_word;
        m   = '{m2, m3, m4};
        smp = '{S2, S3, S4};
        repeat (60) @(posedge mclk);
        clr <= 1'b1;
        repeat (3) @(posedge mclk);
        clr <= 1'b0;
        repeat (170) @(posedge mclk);
        for (int l = 0; l < 2; l++)
            for (int s = 0; s < 64; s++) begin
                e_drv  = 1'b0;
                e_word = 8'h00;
                for (int c = 2; c >= 0; c--)
                    if (m[c][ACSM_LINE_BIT] == l && m[c][5:0] == s) begin
                        e_drv  = 1'b1;
                        e_word = smp[c];
                    end
                `CHK(acsm_host_model_i.drv[l][s], e_drv)
                `CHK(acsm_host_model_i.cap[l][s], e_word)
            end
    endtask

    task automatic t_reset_map;
        logic [31:0] d;
        logic [1:0]  r;
        logic [7:0]  ad [3];
        logic [31:0] ex [3];
        ad = '{ACSM_CH2_ADDR, ACSM_CH3_ADDR, ACSM_CH4_ADDR};
        ex = '{32'h00000001, 32'h00000002, 32'h00000003};
        for (int i = 0; i < 3; i++) begin
            axi_rd(ad[i], d, r);
            `CHK(d, ex[i])
        end
        check_map(7'h01, 7'h02, 7'h03);
    endtask

    // Boundary codes 0 and 63 on the secondary line, 31 on the primary line
    task automatic t_codes;
        set_map(7'h40, 7'h1f, 7'h7f, 1'b0);
        check_map(7'h40, 7'h1f, 7'h7f);
    endtask

    // Two-half framing: right-half codes land after the half restart
    task automatic t_lr;
        lr <= 1'b1;
        set_map(7'h20, 7'h4f, 7'h2f, 1'b1);
        check_map(7'h20, 7'h4f, 7'h2f);
    endtask

    task automatic t_bus;
        logic [31:0] d;
        logic [1:0]  r;
        // Framing still two-half; status settled: nothing pending, link active
        axi_rd(ACSM_CFG_ADDR, d, r);
        `CHK(d, 32'h00000001)
        axi_wr(ACSM_STAT_ADDR, 32'hffffffff, 4'hf, r);
        `CHK(r, ACSM_RESP_OK)
        axi_rd(ACSM_STAT_ADDR, d, r);
        `CHK({r, d}, {ACSM_RESP_OK, 32'h00000002})
        axi_wr(ACSM_CH3_ADDR, 32'hffffffff, 4'hf, r);
        `CHK(r, ACSM_RESP_OK)
        axi_rd(ACSM_CH3_ADDR, d, r);
        `CHK(d, 32'h0000007f)
        axi_wr(ACSM_CH4_ADDR, 32'h00000011, 4'h0, r);
        axi_rd(ACSM_CH4_ADDR, d, r);
        `CHK(d, 32'h0000002f)
        axi_wr(8'h3c, 32'h00000005, 4'hf, r);
        `CHK(r, ACSM_RESP_ERR)
        axi_rd(8'h3c, d, r);
        `CHK({r, d}, {ACSM_RESP_ERR, 32'h00000000})
    endtask

    task automatic results;
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence; framing starts only after the link side is out of reset
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        run <= 1'b1;
        @(posedge mclk);
        t_reset_map();
        t_codes();
        t_lr();
        t_bus();
        results();
    end

    // Watchdog, several times the expected run
    initial begin
        #100000;
        failures++;
        results();
    end
endmodule
